/* File: umfc_pkg.sv */
package umfc_pkg;
	localparam int          UMFC_AW        = 8;
	localparam int          UMFC_LVL_W     = 8;
	localparam logic [7:0]  OFS_LINE_CTRL  = 8'h00;
	localparam logic [7:0]  OFS_MODEM_CTRL = 8'h04;
	localparam logic [7:0]  OFS_MODEM_STAT = 8'h08;
	localparam logic [7:0]  OFS_SCRATCH    = 8'h0C;
	localparam logic [7:0]  OFS_DIV_LOW    = 8'h10;
	localparam logic [7:0]  OFS_DIV_HIGH   = 8'h14;
	localparam logic [7:0]  OFS_ENH_FEAT   = 8'h18;
	localparam logic [7:0]  OFS_RESUME_A   = 8'h1C;
	localparam logic [7:0]  OFS_RESUME_B   = 8'h20;
	localparam logic [7:0]  OFS_PAUSE_A    = 8'h24;
	localparam logic [7:0]  OFS_PAUSE_B    = 8'h28;
	localparam logic [7:0]  OFS_INDEXED    = 8'h2C;
	localparam logic [7:0]  OFS_ADD_STAT   = 8'h30;
	localparam logic [7:0]  OFS_INT_EN     = 8'h34;
	localparam logic [7:0]  OFS_UPPER_TRIG = 8'h38;
	localparam logic [7:0]  OFS_LOWER_TRIG = 8'h3C;
	localparam logic [7:0]  IDX_PRESCALER  = 8'h01;
	localparam logic [7:0]  LINE_UNLOCK    = 8'hBF;
	localparam logic [7:0]  PRESC_RST      = 8'h20;
	localparam logic [15:0] DIV_RST        = 16'h0001;
	localparam logic [7:0]  UPPER_RST      = 8'h60;
	localparam logic [7:0]  LOWER_RST      = 8'h20;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
	localparam logic [1:0]  FLOW_OFF       = 2'b00;
	localparam logic [1:0]  FLOW_PAIR_B    = 2'b01;
	localparam logic [1:0]  FLOW_PAIR_A    = 2'b10;
	localparam logic [1:0]  FLOW_EITHER    = 2'b11;
	localparam int          MC_DTR         = 0;
	localparam int          MC_RTS         = 1;
	localparam int          MC_USER_A      = 2;
	localparam int          MC_USER_B      = 3;
	localparam int          MC_LOOP        = 4;
	localparam int          MC_XANY        = 5;
	localparam int          MC_IRDA        = 6;
	localparam int          MC_PRESC       = 7;
	localparam int          EF_RXF         = 0;
	localparam int          EF_TXF         = 2;
	localparam int          EF_ENH         = 4;
	localparam int          EF_SPEC        = 5;
	localparam int          EF_ARTS        = 6;
	localparam int          EF_ACTS        = 7;
	localparam int          AS_RX_HOLD     = 0;
	localparam int          AS_TX_SENT     = 1;
	localparam int          AS_SPEC        = 4;
	localparam int          IE_LEVEL5      = 5;
	localparam int          IE_ENH_LO      = 4;
	localparam int          MS_RI          = 2;
endpackage : umfc_pkg

/* File: umfc_top.sv */
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module umfc_top
	import umfc_pkg::*;
#(
	parameter int LVL_W = UMFC_LVL_W
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [UMFC_AW-1:0] paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             cts_n,
	input  wire logic             dsr_n,
	input  wire logic             ri_n,
	input  wire logic             dcd_n,
	output logic                  rts_n,
	output logic                  dtr_n,
	output logic                  user_output_a_n,
	output logic                  user_output_b_n,
	input  wire logic             rx_valid,
	input  wire logic [7:0]       rx_data,
	input  wire logic             nine_bit,
	input  wire logic [LVL_W-1:0] receive_fifo_level,
	input  wire logic             tx_slot,
	output logic                  tx_ins_valid,
	output logic      [7:0]       tx_ins_char,
	output logic                  tx_allow,
	output logic                  rx_store,
	output logic                  level5_irq,
	output logic      [15:0]      divisor,
	output logic                  presc_sel,
	output logic      [7:0]       presc_value,
	output logic                  irda_sel,
	output logic                  loopback
);
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q;
	logic [7:0]  line_control_q, modem_control_q, scratch_pad_q;
	logic [7:0]  divisor_low_q, divisor_high_q, enhanced_features_q;
	logic [7:0]  resume_char_a_q, resume_char_b_q;
	logic [7:0]  pause_char_a_q, pause_char_b_q;
	logic [7:0]  fractional_prescaler_q, interrupt_enable_q;
	logic [7:0]  upper_trig_q, lower_trig_q;
	logic        unlock_q;
	logic [3:0]  stat_prev_q, delta_q, stat_cur, stat_chg;
	logic        hold_q, sent_q, spec_q, pair_a_q, spec_d;
	logic        rts_block_q, rts_n_q, dtr_n_q, ua_n_q, ub_n_q;
	logic        ins_valid_q, tx_allow_q, rx_store_q, irq_q, irda_q;
	logic [7:0]  ins_char_q;
	logic        acc_start, done, wr, rd;
	logic        enh, loop, inb_en, spec_en, arts_en, acts_en, txon;
	logic        xoff_hit, xon_hit, spec_hit, keep;
	logic [1:0]  rxm, txm;
	logic [7:0]  mc_next;
	logic [31:0] rd_data;
	logic        rd_err;

	assign acc_start = psel & penable & ~pready_q;
	assign done      = psel & penable & pready_q;
	assign wr        = done & pwrite;
	// Read side effects fall on the edge that latches prdata
	assign rd        = acc_start & ~pwrite;
	assign enh       = enhanced_features_q[EF_ENH];
	assign loop      = modem_control_q[MC_LOOP];
	assign rxm       = enhanced_features_q[EF_RXF +: 2];
	assign txm       = enhanced_features_q[EF_TXF +: 2];

	// One wait state keeps pready and prdata both registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= WORD_ZERO;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= acc_start;
			if (acc_start) begin
				prdata_q  <= rd_data;
				pslverr_q <= rd_err;
			end
		end
	end

	always_comb begin
		rd_data = WORD_ZERO;
		rd_err  = 1'b0;
		unique case (paddr)
			OFS_LINE_CTRL:  rd_data[7:0] = line_control_q;
			OFS_MODEM_CTRL: rd_data[7:0] = modem_control_q;
			OFS_MODEM_STAT: rd_data[7:0] = {stat_cur, delta_q};
			OFS_SCRATCH:    rd_data[7:0] = scratch_pad_q;
			OFS_DIV_LOW:    rd_data[7:0] = divisor_low_q;
			OFS_DIV_HIGH:   rd_data[7:0] = divisor_high_q;
			OFS_ENH_FEAT:   rd_data[7:0] = enhanced_features_q;
			OFS_RESUME_A:   rd_data[7:0] = resume_char_a_q;
			OFS_RESUME_B:   rd_data[7:0] = resume_char_b_q;
			OFS_PAUSE_A:    rd_data[7:0] = pause_char_a_q;
			OFS_PAUSE_B:    rd_data[7:0] = pause_char_b_q;
			OFS_INDEXED: begin
				if (scratch_pad_q == IDX_PRESCALER)
					rd_data[7:0] = fractional_prescaler_q;
			end
			OFS_ADD_STAT: begin
				rd_data[AS_RX_HOLD] = hold_q;
				rd_data[AS_TX_SENT] = sent_q;
				rd_data[AS_SPEC]    = spec_q;
			end
			OFS_INT_EN:     rd_data[7:0] = interrupt_enable_q;
			OFS_UPPER_TRIG: rd_data[7:0] = upper_trig_q;
			OFS_LOWER_TRIG: rd_data[7:0] = lower_trig_q;
			default:        rd_err = 1'b1;
		endcase
	end

	// Unlock code only raises bit 7, the data format stays put
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_control_q <= BYTE_ZERO;
			unlock_q       <= 1'b0;
		end else if (wr && paddr == OFS_LINE_CTRL) begin
			if (pwdata[7:0] == LINE_UNLOCK) begin
				line_control_q[7] <= 1'b1;
				unlock_q          <= 1'b1;
			end else begin
				line_control_q <= pwdata[7:0];
				unlock_q       <= 1'b0;
			end
		end
	end

	always_comb begin
		mc_next = pwdata[7:0];
		if (!enh)
			mc_next[MC_PRESC] = modem_control_q[MC_PRESC];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_control_q     <= BYTE_ZERO;
			scratch_pad_q       <= BYTE_ZERO;
			divisor_low_q       <= DIV_RST[7:0];
			divisor_high_q      <= DIV_RST[15:8];
			enhanced_features_q <= BYTE_ZERO;
			interrupt_enable_q  <= BYTE_ZERO;
			upper_trig_q        <= UPPER_RST;
			lower_trig_q        <= LOWER_RST;
		end else if (wr) begin
			unique case (paddr)
				OFS_MODEM_CTRL: modem_control_q <= mc_next;
				OFS_SCRATCH:    scratch_pad_q   <= pwdata[7:0];
				OFS_DIV_LOW:    divisor_low_q   <= pwdata[7:0];
				OFS_DIV_HIGH:   divisor_high_q  <= pwdata[7:0];
				OFS_ENH_FEAT: begin
					// Writes ignored unless the unlock code is in place; reads always return it
					if (unlock_q)
						enhanced_features_q <= pwdata[7:0];
				end
				OFS_INT_EN:     interrupt_enable_q <= pwdata[7:0];
				OFS_UPPER_TRIG: upper_trig_q       <= pwdata[7:0];
				OFS_LOWER_TRIG: lower_trig_q       <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_char_a_q        <= BYTE_ZERO;
			resume_char_b_q        <= BYTE_ZERO;
			pause_char_a_q         <= BYTE_ZERO;
			pause_char_b_q         <= BYTE_ZERO;
			fractional_prescaler_q <= PRESC_RST;
		end else if (wr) begin
			unique case (paddr)
				OFS_RESUME_A: resume_char_a_q <= pwdata[7:0];
				OFS_RESUME_B: resume_char_b_q <= pwdata[7:0];
				OFS_PAUSE_A:  pause_char_a_q  <= pwdata[7:0];
				OFS_PAUSE_B:  pause_char_b_q  <= pwdata[7:0];
				OFS_INDEXED: begin
					if (scratch_pad_q == IDX_PRESCALER)
						fractional_prescaler_q <= pwdata[7:0];
				end
				default: ;
			endcase
		end
	end

	// Bit order: 0 clear-to-send, 1 set-ready, 2 ring, 3 carrier
	always_comb begin
		if (loop)
			stat_cur = {modem_control_q[MC_USER_B],
			            modem_control_q[MC_USER_A],
			            modem_control_q[MC_DTR],
			            modem_control_q[MC_RTS]};
		else
			stat_cur = ~{dcd_n, ri_n, dsr_n, cts_n};
		stat_chg = stat_cur ^ stat_prev_q;
		stat_chg[MS_RI] = stat_prev_q[MS_RI] & ~stat_cur[MS_RI];
	end

	// A change in the read cycle survives the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_prev_q <= 4'h0;
			delta_q     <= 4'h0;
		end else begin
			stat_prev_q <= stat_cur;
			if (rd && paddr == OFS_MODEM_STAT)
				delta_q <= stat_chg;
			else
				delta_q <= delta_q | stat_chg;
		end
	end

	assign inb_en  = enh & ~nine_bit;
	assign spec_en = enh & enhanced_features_q[EF_SPEC];
	assign arts_en = enh ? enhanced_features_q[EF_ARTS]
	                     : modem_control_q[MC_XANY];
	assign acts_en = enh ? enhanced_features_q[EF_ACTS]
	                     : modem_control_q[MC_XANY];
	assign txon    = inb_en & (txm == FLOW_PAIR_B | txm == FLOW_PAIR_A);

	always_comb begin
		xoff_hit = 1'b0;
		xon_hit  = 1'b0;
		unique case (rxm)
			FLOW_OFF: ;
			FLOW_PAIR_B: begin
				xoff_hit = rx_data == pause_char_b_q;
				xon_hit  = rx_data == resume_char_b_q;
			end
			FLOW_PAIR_A: begin
				xoff_hit = rx_data == pause_char_a_q;
				xon_hit  = rx_data == resume_char_a_q;
			end
			FLOW_EITHER: begin
				xoff_hit = txon & (rx_data == pause_char_a_q |
				                   rx_data == pause_char_b_q);
				xon_hit  = txon & (rx_data == resume_char_a_q |
				                   rx_data == resume_char_b_q);
			end
		endcase
		xoff_hit = xoff_hit & inb_en;
		xon_hit  = xon_hit & inb_en;
	end

	assign spec_hit = spec_en & rx_data == pause_char_b_q;
	// Flow characters are swallowed, except a special-case pause
	assign keep = ~(xoff_hit | xon_hit) | spec_hit;
	assign spec_d = (rd && paddr == OFS_ADD_STAT) ? 1'b0 : spec_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q     <= 1'b0;
			spec_q     <= 1'b0;
			rx_store_q <= 1'b0;
		end else begin
			rx_store_q <= rx_valid & keep;
			spec_q     <= spec_d | (rx_valid & spec_hit);
			if (!inb_en || rxm == FLOW_OFF)
				hold_q <= 1'b0;
			else if (rx_valid && !hold_q && xoff_hit)
				hold_q <= 1'b1;
			else if (rx_valid && hold_q &&
			         (xon_hit || modem_control_q[MC_XANY]))
				hold_q <= 1'b0;
		end
	end

	// Transmitter only looks at this between characters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_allow_q <= 1'b1;
		else
			tx_allow_q <= ~hold_q &
			              ~(acts_en & ~stat_cur[0]);
	end

	// Insertion happens only in idle slots the transmitter offers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sent_q      <= 1'b0;
			pair_a_q    <= 1'b0;
			ins_valid_q <= 1'b0;
			ins_char_q  <= BYTE_ZERO;
		end else begin
			ins_valid_q <= 1'b0;
			if (tx_slot && !ins_valid_q && !nine_bit) begin
				if (txon && !sent_q &&
				    receive_fifo_level > upper_trig_q) begin
					sent_q      <= 1'b1;
					ins_valid_q <= 1'b1;
					pair_a_q    <= txm == FLOW_PAIR_A;
					ins_char_q  <= (txm == FLOW_PAIR_A) ?
					               pause_char_a_q : pause_char_b_q;
				end else if (sent_q && (!txon ||
				             receive_fifo_level < lower_trig_q)) begin
					sent_q      <= 1'b0;
					ins_valid_q <= 1'b1;
					ins_char_q  <= pair_a_q ?
					               resume_char_a_q : resume_char_b_q;
				end
			end
		end
	end

	// Software clearing RTS always overrides the automatic control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rts_block_q <= 1'b0;
			rts_n_q     <= 1'b1;
			dtr_n_q     <= 1'b1;
			ua_n_q      <= 1'b1;
			ub_n_q      <= 1'b1;
		end else begin
			if (receive_fifo_level >= upper_trig_q)
				rts_block_q <= 1'b1;
			else if (receive_fifo_level < lower_trig_q)
				rts_block_q <= 1'b0;
			rts_n_q <= loop | ~(modem_control_q[MC_RTS] &
			           ~(arts_en & rts_block_q));
			dtr_n_q <= loop | ~modem_control_q[MC_DTR];
			ua_n_q  <= loop | modem_control_q[MC_USER_A];
			ub_n_q  <= loop | modem_control_q[MC_USER_B];
		end
	end

	// Infrared framing needs the 16x sample clock downstream
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irda_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			irda_q <= enh & modem_control_q[MC_IRDA];
			irq_q  <= enh & interrupt_enable_q[IE_LEVEL5] &
			          (spec_q | hold_q);
		end
	end

	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign rts_n           = rts_n_q;
	assign dtr_n           = dtr_n_q;
	assign user_output_a_n = ua_n_q;
	assign user_output_b_n = ub_n_q;
	assign tx_ins_valid    = ins_valid_q;
	assign tx_ins_char     = ins_char_q;
	assign tx_allow        = tx_allow_q;
	assign rx_store        = rx_store_q;
	assign level5_irq      = irq_q;
	assign divisor = {divisor_high_q, divisor_low_q};
	assign presc_sel       = modem_control_q[MC_PRESC];
	assign presc_value     = fractional_prescaler_q;
	assign irda_sel        = irda_q;
	assign loopback        = modem_control_q[MC_LOOP];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_presc_lock: assert property (
		wr && paddr == OFS_MODEM_CTRL && !enh |=> $stable(presc_sel))
		else $error("prescaler select changed outside enhanced");
	a_ring_edge: assert property (
		!loop && $rose(ri_n) |=> delta_q[MS_RI])
		else $error("ring trailing edge not flagged");
	a_loop_map: assert property (
		loop |-> stat_cur[0] == modem_control_q[MC_RTS] ##1 rts_n)
		else $error("loopback mapping wrong");
	a_unlock_keep: assert property (
		wr && paddr == OFS_LINE_CTRL && pwdata[7:0] == LINE_UNLOCK
		|=> line_control_q[7] &&
		    line_control_q[6:0] == $past(line_control_q[6:0]))
		else $error("unlock code altered data format");
	a_nine_quiet: assert property (
		nine_bit [*2] |-> !tx_ins_valid && !hold_q)
		else $error("in-band flow active in 9-bit mode");
	a_pause_halt: assert property (
		rx_valid && xoff_hit && !hold_q |=> hold_q ##1 !tx_allow)
		else $error("pause char did not halt transmit");
	a_ins_pause: assert property (
		$rose(sent_q) |-> tx_ins_valid &&
		(tx_ins_char == pause_char_a_q || tx_ins_char == pause_char_b_q))
		else $error("pause insertion missing");
	a_rts_block: assert property (
		rts_block_q && arts_en && !loop |=> rts_n)
		else $error("auto RTS not inactive");
	a_cts_block: assert property (
		acts_en && !loop && cts_n |=> !tx_allow)
		else $error("transmit not blocked by CTS");
	a_spec_flag: assert property (
		rx_valid && spec_hit |=> spec_q && rx_store)
		else $error("special character not flagged");
	a_apb_wait: assert property (
		acc_start |=> pready ##1 !pready)
		else $error("pready not one cycle after one wait");

	c_pause_resume: cover property (
		$rose(hold_q) ##[1:50] $fell(hold_q));
	c_insert_resume: cover property ($fell(sent_q) && tx_ins_valid);
	c_special: cover property ($rose(spec_q));
	c_cts_stop: cover property (acts_en && $fell(tx_allow));
endmodule : umfc_top

/* File: umfc_modem_model.sv */
`timescale 1ns/1ps
// Far-end modem: handshake pins idle inactive high
module umfc_modem_model (
	input  wire logic pclk,
	input  wire logic rts_n,
	input  wire logic dtr_n,
	output logic      cts_n,
	output logic      dsr_n,
	output logic      ri_n,
	output logic      dcd_n
);
	initial begin
		{dcd_n, ri_n, dsr_n, cts_n} = 4'b1111;
	end

	// Pins in order dcd, ri, dsr, cts; dly lets the far end answer late
	task set_pins(input logic [3:0] v, input int dly);
		repeat (dly + 1) @(posedge pclk);
		{dcd_n, ri_n, dsr_n, cts_n} <= v;
	endtask : set_pins
endmodule : umfc_modem_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import umfc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, rx_data, lvl, tx_ins_char, presc_value;
	logic [31:0] pwdata, prdata, rv;
	logic        cts_n, dsr_n, ri_n, dcd_n, rts_n, dtr_n, loopback;
	logic        rx_valid, nine_bit, tx_slot, tx_ins_valid, tx_allow;
	logic        rx_store, level5_irq, presc_sel, irda_sel, re, st;
	logic [15:0] divisor;
	logic [7:0]  ec, pc, rc;
	logic        ua_n, ub_n;
	int          errors, total_checks;

	umfc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
		.dcd_n(dcd_n), .rts_n(rts_n), .dtr_n(dtr_n),
		.user_output_a_n(ua_n), .user_output_b_n(ub_n),
		.rx_valid(rx_valid),
		.rx_data(rx_data), .nine_bit(nine_bit),
		.receive_fifo_level(lvl), .tx_slot(tx_slot),
		.tx_ins_valid(tx_ins_valid), .tx_ins_char(tx_ins_char),
		.tx_allow(tx_allow), .rx_store(rx_store), .level5_irq(level5_irq),
		.divisor(divisor), .presc_sel(presc_sel), .presc_value(presc_value),
		.irda_sel(irda_sel), .loopback(loopback));

	umfc_modem_model modem (.pclk(pclk), .rts_n(rts_n), .dtr_n(dtr_n),
		.cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));

	task complete_run;
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Request held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
		settle();
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, BYTE_ZERO);
		chk(rv, {24'h00_0000, exp});
	endtask : rd

	task settle;
		repeat (3) @(posedge pclk);
		#1;
	endtask : settle

	task setl(input logic [7:0] v);
		@(posedge pclk);
		lvl <= v;
		settle();
	endtask : setl

	task rxc(input logic [7:0] d);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_data <= d;
		@(posedge pclk);
		rx_valid <= 1'b0;
		#1;
		st = rx_store;
	endtask : rxc

	// Insert pulse lasts one cycle, so look every cycle
	task ins(input logic [7:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (tx_ins_valid !== 1'b1 && n < 20);
		chk({tx_ins_valid, tx_ins_char}, {1'b1, exp});
	endtask : ins

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		complete_run();
	end

	initial begin
		{presetn, psel, penable, pwrite, rx_valid, nine_bit, tx_slot} = 7'h00;
		{paddr, rx_data, lvl, pwdata} = 56'h00_0000_0000_0000;
		errors = 0;
		total_checks = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk({presc_sel, presc_value, divisor, tx_allow}, {1'b0, PRESC_RST, DIV_RST, 1'b1});
		rd(OFS_DIV_LOW, 8'h01);
		wr(OFS_DIV_LOW, 8'h34);
		wr(OFS_DIV_HIGH, 8'h12);
		chk(divisor, 16'h1234);
		wr(OFS_SCRATCH, 8'hA5);
		rd(OFS_SCRATCH, 8'hA5);
		rd(OFS_DIV_LOW, 8'h34);
		apb(1'b0, 8'h40, BYTE_ZERO);
		chk({re, rv}, {1'b1, WORD_ZERO});
		$display("test registers done");
		wr(OFS_MODEM_CTRL, 8'hC0);
		chk({presc_sel, irda_sel}, 2'b00);
		wr(OFS_ENH_FEAT, 8'h10);
		rd(OFS_ENH_FEAT, 8'h00);
		wr(OFS_MODEM_CTRL, 8'h22);
		setl(8'h60);
		chk({tx_allow, rts_n}, 2'b01);
		modem.set_pins(4'b1110, 2);
		setl(8'h00);
		chk({tx_allow, rts_n}, 2'b10);
		$display("test legacy done");
		wr(OFS_LINE_CTRL, 8'h03);
		wr(OFS_LINE_CTRL, LINE_UNLOCK);
		rd(OFS_LINE_CTRL, 8'h83);
		wr(OFS_ENH_FEAT, 8'h10);
		rd(OFS_ENH_FEAT, 8'h10);
		wr(OFS_MODEM_CTRL, 8'hC0);
		chk({presc_sel, irda_sel}, 2'b11);
		wr(OFS_SCRATCH, IDX_PRESCALER);
		wr(OFS_INDEXED, 8'h4B);
		chk(presc_value, 8'h4B);
		$display("test enhanced done");
		modem.set_pins(4'b1111, 0);
		settle();
		apb(1'b0, OFS_MODEM_STAT, BYTE_ZERO);
		modem.set_pins(4'b0000, 0);
		settle();
		rd(OFS_MODEM_STAT, 8'hFB);
		rd(OFS_MODEM_STAT, 8'hF0);
		modem.set_pins(4'b0100, 0);
		settle();
		rd(OFS_MODEM_STAT, 8'hB4);
		wr(OFS_MODEM_CTRL, 8'h17);
		apb(1'b0, OFS_MODEM_STAT, BYTE_ZERO);
		chk(rv & 32'h0000_00F0, 32'h0000_0070);
		chk({rts_n, dtr_n, ua_n, ub_n, loopback}, 5'b11111);
		wr(OFS_MODEM_CTRL, 8'h02);
		chk({ua_n, ub_n, dtr_n}, 3'b001);
		$display("test status done");
		wr(OFS_ENH_FEAT, 8'h50);
		setl(8'h5F);
		chk(rts_n, 1'b0);
		setl(8'h60);
		chk(rts_n, 1'b1);
		setl(8'h20);
		chk(rts_n, 1'b1);
		setl(8'h1F);
		chk(rts_n, 1'b0);
		wr(OFS_ENH_FEAT, 8'h90);
		modem.set_pins(4'b0101, 0);
		settle();
		chk(tx_allow, 1'b0);
		modem.set_pins(4'b0100, 3);
		settle();
		chk(tx_allow, 1'b1);
		$display("test handshake done");
		wr(OFS_RESUME_A, 8'h11);
		wr(OFS_PAUSE_A, 8'h13);
		wr(OFS_RESUME_B, 8'h12);
		wr(OFS_PAUSE_B, 8'h17);
		wr(OFS_ENH_FEAT, 8'h12);
		rxc(8'h17);
		settle();
		chk({st, tx_allow}, 2'b11);
		rxc(8'h13);
		settle();
		chk({st, tx_allow}, 2'b00);
		rxc(8'h11);
		settle();
		chk({st, tx_allow}, 2'b01);
		wr(OFS_MODEM_CTRL, 8'h22);
		rxc(8'h13);
		rxc(8'h41);
		settle();
		chk({st, tx_allow}, 2'b11);
		@(posedge pclk);
		nine_bit <= 1'b1;
		rxc(8'h13);
		settle();
		chk(tx_allow, 1'b1);
		@(posedge pclk);
		nine_bit <= 1'b0;
		wr(OFS_MODEM_CTRL, 8'h02);
		wr(OFS_ENH_FEAT, 8'h11);
		rxc(8'h13);
		settle();
		chk({st, tx_allow}, 2'b11);
		rxc(8'h17);
		settle();
		chk({st, tx_allow}, 2'b00);
		wr(OFS_ENH_FEAT, 8'h1B);
		rxc(8'h11);
		settle();
		chk({st, tx_allow}, 2'b01);
		$display("test receive flow done");
		for (int i = 0; i < 2; i++) begin
			ec = (i == 0) ? 8'h18 : 8'h14;
			pc = (i == 0) ? 8'h13 : 8'h17;
			rc = (i == 0) ? 8'h11 : 8'h12;
			wr(OFS_ENH_FEAT, ec);
			@(posedge pclk);
			tx_slot <= 1'b1;
			lvl <= 8'h61;
			ins(pc);
			@(posedge pclk);
			lvl <= 8'h10;
			ins(rc);
		end
		@(posedge pclk);
		tx_slot <= 1'b0;
		$display("test transmit flow done");
		wr(OFS_INT_EN, 8'h20);
		wr(OFS_ENH_FEAT, 8'h30);
		rxc(8'h17);
		settle();
		chk({st, level5_irq}, 2'b11);
		rd(OFS_ADD_STAT, 8'h10);
		rd(OFS_ADD_STAT, 8'h00);
		chk(level5_irq, 1'b0);
		$display("test special done");
		complete_run();
	end
endmodule : tb_top
